/* design/acc_pkg.sv */
package acc_pkg;
  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] ACC_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ACC_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ACC_ADDR_MIRROR = 8'h08;
  localparam logic [7:0] ACC_ADDR_IRQ = 8'h0c;
  localparam logic [7:0] ACC_ADDR_PORT = 8'h10;
  localparam int ACC_ADDR_W = 8;

  // comp_control_zero fields
  localparam int C0_ENABLE = 7;
  localparam int C0_RESULT = 6;
  localparam int C0_PIN_OE = 5;
  localparam int C0_INVERT = 4;
  localparam int C0_SPEED = 2;
  localparam int C0_HYST = 1;
  localparam int C0_SYNC = 0;
  // comp_control_one fields
  localparam int C1_RISE = 7;
  localparam int C1_FALL = 6;
  localparam int C1_PSEL_LO = 4;
  localparam int C1_NSEL_LO = 0;
  // irq register fields
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_EN = 1;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE = 2;
  localparam int IRQ_GIE = 3;
  // port register fields
  localparam int PORT_DIR = 0;
  localparam int PORT_LATCH = 1;
  localparam int PORT_ANALOG = 2;
  localparam int PORT_PIN = 3;

  // Reset values: speed select defaults to normal speed
  localparam logic [7:0] ACC_CTRL0_RST = 8'h04;
  localparam logic [7:0] ACC_CTRL1_RST = 8'h00;
  localparam logic [7:0] ACC_CTRL0_WMASK = 8'hb7;
  localparam logic [7:0] ACC_CTRL1_WMASK = 8'hf7;
  localparam logic [3:0] ACC_PORT_RST = 4'h1;

  typedef enum logic [1:0] {
    ACC_P_PIN = 2'h0,
    ACC_P_DAC = 2'h1,
    ACC_P_FVR = 2'h2,
    ACC_P_GND = 2'h3
  } acc_psel_t;

  typedef enum logic [2:0] {
    ACC_N_PIN0 = 3'h0,
    ACC_N_PIN1 = 3'h1,
    ACC_N_FVR = 3'h6,
    ACC_N_GND = 3'h7
  } acc_nsel_t;

  // One-hot analog switch controls toward the comparator
  typedef struct packed {
    logic [3:0] pos_onehot; // pin, dac, fvr, gnd
    logic [3:0] neg_onehot; // pin0, pin1, fvr, gnd
    logic enable;
    logic speed_power_sel;
    logic hysteresis_enable;
  } acc_analog_t;

  typedef enum logic [1:0] {
    ACC_BUS_ADDR = 2'b01,
    ACC_BUS_DATA = 2'b10
  } acc_bus_state_t;
endpackage : acc_pkg

/* design/acc_top.sv */
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module acc_top
  import acc_pkg::*;
#(
  parameter int SYNC_STAGES = 3
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comp_raw,
  input wire logic timer_clk,
  input wire logic timer_presc_clk,
  input wire logic timer_presc_en,
  input wire logic pin_in,
  output acc_analog_t analog_ctrl_q,
  output logic sync_result_q,
  output logic async_result_q,
  output logic pin_out_q,
  output logic pin_oe_q,
  output logic irq_q
);
  localparam int SYNC_MIN_STAGES = 3;
  localparam int SYNC_INPUTS = 3;
  localparam int SYNC_COMP = 0;
  localparam int SYNC_TCLK = 1;
  localparam int SYNC_PIN = 2;

  acc_bus_state_t bus_q;
  logic [ACC_ADDR_W-1:0] addr_q;
  logic wr_q;
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [3:1] irq_en_q;
  logic [3:0] port_q;
  logic [SYNC_STAGES-1:0] chain_q [SYNC_INPUTS];
  logic chain_level_q [SYNC_INPUTS];
  logic [SYNC_INPUTS-1:0] chain_in;
  logic result_q;
  logic result_prev_q;
  logic sync_hold_q;
  logic edge_flag_q;
  logic comp_level;
  logic polarized;
  logic tclk_fell;
  logic rise_evt;
  logic fall_evt;
  logic flag_set;
  logic flag_clr;
  logic addr_take;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_irq;
  logic wr_port;
  logic [31:0] rdata_d;

  // Fewer stages cannot tell a settled level from a metastable one
  if (SYNC_STAGES < SYNC_MIN_STAGES) begin : g_bad_stages
    $error("acc_top needs at least three synchroniser stages");
  end

  function automatic logic is_write(input logic [ACC_ADDR_W-1:0] a, input logic [ACC_ADDR_W-1:0] reg_addr,
                                    input logic w, input acc_bus_state_t st);
    return (st == ACC_BUS_DATA) && w && (a == reg_addr);
  endfunction : is_write

  function automatic logic [3:0] pos_switch(input acc_psel_t sel);
    case (sel)
      ACC_P_PIN: return 4'h1;
      ACC_P_DAC: return 4'h2;
      ACC_P_FVR: return 4'h4;
      ACC_P_GND: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction : pos_switch

  function automatic logic [3:0] neg_switch(input acc_nsel_t sel);
    case (sel)
      ACC_N_PIN0: return 4'h1;
      ACC_N_PIN1: return 4'h2;
      ACC_N_FVR: return 4'h4;
      ACC_N_GND: return 4'h8;
      default: return 4'h0; // Reserved codes leave every switch open
    endcase
  endfunction : neg_switch

  assign addr_take = hready && hsel && htrans[1];

  // Two-state bus tracker; the slave never stretches a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= ACC_BUS_ADDR;
    end else if (hready) begin
      case (bus_q)
        ACC_BUS_ADDR: bus_q <= addr_take ? ACC_BUS_DATA : ACC_BUS_ADDR;
        ACC_BUS_DATA: bus_q <= addr_take ? ACC_BUS_DATA : ACC_BUS_ADDR;
        default: bus_q <= ACC_BUS_ADDR;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
      wr_q <= 1'b0;
    end else if (addr_take) begin
      addr_q <= haddr[ACC_ADDR_W-1:0];
      wr_q <= hwrite;
    end
  end

  // Zero wait states and OKAY only, still launched from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_ctrl0 = is_write(addr_q, ACC_ADDR_CTRL0, wr_q, bus_q);
  assign wr_ctrl1 = is_write(addr_q, ACC_ADDR_CTRL1, wr_q, bus_q);
  assign wr_irq = is_write(addr_q, ACC_ADDR_IRQ, wr_q, bus_q);
  assign wr_port = is_write(addr_q, ACC_ADDR_PORT, wr_q, bus_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_q <= ACC_CTRL0_RST;
    end else if (wr_ctrl0) begin
      ctrl0_q <= hwdata[7:0] & ACC_CTRL0_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_q <= ACC_CTRL1_RST;
    end else if (wr_ctrl1) begin
      ctrl1_q <= hwdata[7:0] & ACC_CTRL1_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= '0;
    end else if (wr_irq) begin
      irq_en_q <= {hwdata[IRQ_GIE], hwdata[IRQ_PERIPHERAL_IRQ_ENABLE], hwdata[IRQ_EN]};
    end
  end

  // Pin level bit is read-only, so it is never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_q <= ACC_PORT_RST;
    end else if (wr_port) begin
      port_q <= {1'b0, hwdata[PORT_ANALOG], hwdata[PORT_LATCH], hwdata[PORT_DIR]};
    end
  end

  assign chain_in[SYNC_COMP] = comp_raw;
  assign chain_in[SYNC_TCLK] = timer_presc_en ? timer_presc_clk : timer_clk;
  assign chain_in[SYNC_PIN] = pin_in;

  // Foreign inputs: a change counts once the last two stages agree
  for (genvar g = 0; g < SYNC_INPUTS; g++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        chain_q[g] <= '0;
      end else begin
        chain_q[g] <= {chain_q[g][SYNC_STAGES-2:0], chain_in[g]};
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        chain_level_q[g] <= 1'b0;
      end else if (chain_q[g][SYNC_STAGES-1] == chain_q[g][SYNC_STAGES-2]) begin
        chain_level_q[g] <= chain_q[g][SYNC_STAGES-1];
      end
    end
  end

  // Falling edge: accepted level high, last two stages now low
  assign tclk_fell = chain_level_q[SYNC_TCLK] && !chain_q[SYNC_TCLK][SYNC_STAGES-1]
    && !chain_q[SYNC_TCLK][SYNC_STAGES-2];

  // Disabled comparator reads low; polarity applied after
  assign comp_level = ctrl0_q[C0_ENABLE] & chain_level_q[SYNC_COMP];
  assign polarized = comp_level ^ ctrl0_q[C0_INVERT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 1'b0;
    end else begin
      result_q <= polarized;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_prev_q <= 1'b0;
    end else begin
      result_prev_q <= result_q;
    end
  end

  // Latched on the fall so the timer never counts mid-change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_hold_q <= 1'b0;
    end else if (tclk_fell) begin
      sync_hold_q <= result_q;
    end
  end

  assign rise_evt = result_q && !result_prev_q;
  assign fall_evt = !result_q && result_prev_q;
  assign flag_set = (rise_evt && ctrl1_q[C1_RISE]) || (fall_evt && ctrl1_q[C1_FALL]);
  assign flag_clr = wr_irq && !hwdata[IRQ_FLAG];

  // A new edge during the clearing write keeps the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_flag_q <= 1'b0;
    end else if (flag_set) begin
      edge_flag_q <= 1'b1;
    end else if (flag_clr) begin
      edge_flag_q <= 1'b0;
    end
  end

  // Analog switch controls, all open while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_ctrl_q <= '0;
    end else begin
      analog_ctrl_q.enable <= ctrl0_q[C0_ENABLE];
      analog_ctrl_q.speed_power_sel <= ctrl0_q[C0_SPEED];
      analog_ctrl_q.hysteresis_enable <= ctrl0_q[C0_HYST];
      if (ctrl0_q[C0_ENABLE]) begin
        analog_ctrl_q.pos_onehot <= pos_switch(acc_psel_t'(ctrl1_q[C1_PSEL_LO +: $bits(acc_psel_t)]));
        analog_ctrl_q.neg_onehot <= neg_switch(acc_nsel_t'(ctrl1_q[C1_NSEL_LO +: $bits(acc_nsel_t)]));
      end else begin
        analog_ctrl_q.pos_onehot <= '0;
        analog_ctrl_q.neg_onehot <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_result_q <= 1'b0;
    end else begin
      sync_result_q <= ctrl0_q[C0_SYNC] ? sync_hold_q : result_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_result_q <= 1'b0;
    end else begin
      async_result_q <= polarized;
    end
  end

  // OE overrides the latch whatever enable says; enable only gates the result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= 1'b0;
    end else begin
      pin_out_q <= ctrl0_q[C0_PIN_OE] ? (ctrl0_q[C0_ENABLE] && result_q) : port_q[PORT_LATCH];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= !port_q[PORT_DIR];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= edge_flag_q && irq_en_q[IRQ_EN] && irq_en_q[IRQ_PERIPHERAL_IRQ_ENABLE] && irq_en_q[IRQ_GIE];
    end
  end

  always_comb begin
    rdata_d = '0;
    case (addr_q)
      ACC_ADDR_CTRL0: rdata_d[7:0] = {ctrl0_q[7], result_q, ctrl0_q[5:0]};
      ACC_ADDR_CTRL1: rdata_d[7:0] = ctrl1_q;
      ACC_ADDR_MIRROR: rdata_d[0] = result_q;
      ACC_ADDR_IRQ: rdata_d[3:0] = {irq_en_q, edge_flag_q};
      ACC_ADDR_PORT: rdata_d[3:0] = {chain_level_q[SYNC_PIN] && !port_q[PORT_ANALOG], port_q[2:0]};
      default: rdata_d = '0;
    endcase
  end

  // Read data must stand within the zero-wait data phase
  assign hrdata = (bus_q == ACC_BUS_DATA) ? rdata_d : '0;
endmodule : acc_top
`default_nettype wire

/* test/acc_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_top_asserts
  import acc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic comp_raw,
  input wire acc_analog_t analog_ctrl_q,
  input wire logic async_result_q,
  input wire logic pin_out_q,
  input wire logic pin_oe_q
);
  logic wr_q;
  logic [7:0] c0_q;
  // Shadow of control zero, so checks need no peek inside
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      c0_q <= ACC_CTRL0_RST;
    end else begin
      wr_q <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == ACC_ADDR_CTRL0;
      if (wr_q) begin
        c0_q <= hwdata[7:0] & ACC_CTRL0_WMASK;
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OFF: assert property (!analog_ctrl_q.enable |-> analog_ctrl_q.pos_onehot == 4'h0 &&
    analog_ctrl_q.neg_onehot == 4'h0) else $error("inputs connected while disabled");
  AST_POS: assert property (analog_ctrl_q.enable |-> $onehot(analog_ctrl_q.pos_onehot))
    else $error("positive switch not one-hot");
  AST_NEG: assert property (analog_ctrl_q.enable |-> $onehot0(analog_ctrl_q.neg_onehot))
    else $error("negative switches overlap");
  AST_PIN: assert property (c0_q[C0_PIN_OE] && !c0_q[C0_ENABLE] |=> !pin_out_q)
    else $error("result on pin while off");
  AST_OE: assert property (c0_q[C0_PIN_OE] && c0_q[C0_ENABLE] |=> pin_out_q == $past(async_result_q))
    else $error("pin not carrying result");
  AST_SPD: assert property ($rose(hresetn) |-> ##[0:1] analog_ctrl_q.speed_power_sel)
    else $error("speed select not normal after reset");
  AST_EN: assert property (wr_q |=> ##[0:2] analog_ctrl_q.enable == c0_q[C0_ENABLE] &&
    analog_ctrl_q.hysteresis_enable == c0_q[C0_HYST]) else $error("enable or hysteresis lost");
  AST_RES: assert property (($stable(comp_raw) && $stable(c0_q)) [*6] |->
    async_result_q == ((comp_raw && c0_q[C0_ENABLE]) ^ c0_q[C0_INVERT])) else $error("result wrong");
endmodule : acc_top_asserts
`default_nettype wire

/* test/acc_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_far_model (
  input wire logic level,
  output logic comp_raw,
  output logic timer_clk,
  output logic [7:0] tmr_cnt_q
);
  initial begin
    timer_clk = 1'b0;
    tmr_cnt_q = 8'h00;
    forever #70 timer_clk = ~timer_clk;
  end
  // Analog settling, unrelated to the bus clock
  assign #5 comp_raw = level;
  always @(posedge timer_clk) begin
    tmr_cnt_q <= tmr_cnt_q + 8'h01;
  end
endmodule : acc_far_model
`default_nettype wire

/* test/analog_comparator_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_control_tb_top;
  import acc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, level, pin_in, hreadyout, hresp, comp_raw, timer_clk;
  logic sync_result_q, async_result_q, pin_out_q, pin_oe_q, irq_q, presc_en, presc_clk;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] cnt;
  acc_analog_t analog_ctrl_q;
  int errors, total_checks, i;
  `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
  assign hready = hreadyout;
  acc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .comp_raw, .timer_clk, .timer_presc_clk(presc_clk), .timer_presc_en(presc_en),
    .pin_in, .analog_ctrl_q, .sync_result_q, .async_result_q, .pin_out_q, .pin_oe_q, .irq_q);
  acc_far_model far (.level, .comp_raw, .timer_clk, .tmr_cnt_q(cnt));
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy, rsp;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    // Sample away from the edge that launches the answer
    do begin
      @(negedge hclk);
      rdy = hready;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rdy = hready;
      rsp = hresp;
      rd = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    `CHK(rsp, 1'b0)
  endtask : xfer
  task automatic t_mux;
    xfer(0, ACC_ADDR_CTRL0, 0);
    `CHK(rd[7:0], ACC_CTRL0_RST)
    xfer(1, ACC_ADDR_CTRL0, 32'h84);
    tick(2);
    `CHK({analog_ctrl_q.enable, analog_ctrl_q.speed_power_sel, analog_ctrl_q.hysteresis_enable}, 3'b110)
    for (i = 0; i < 8; i++) begin
      xfer(1, ACC_ADDR_CTRL1, i | (i % 4) << C1_PSEL_LO);
      tick(2);
      `CHK($countones(analog_ctrl_q.pos_onehot), 1)
      `CHK($countones(analog_ctrl_q.neg_onehot), (i inside {[2:5]}) ? 0 : 1)
    end
    xfer(1, ACC_ADDR_CTRL0, 32'h02);
    xfer(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    `CHK({analog_ctrl_q.pos_onehot, analog_ctrl_q.neg_onehot, analog_ctrl_q.hysteresis_enable}, 9'h001)
    $display("t_mux done");
  endtask : t_mux
  task automatic t_result;
    level <= 1'b1;
    xfer(1, ACC_ADDR_CTRL0, 32'h80);
    tick(8);
    xfer(0, ACC_ADDR_CTRL0, 0);
    `CHK(rd[C0_RESULT], 1'b1)
    xfer(0, ACC_ADDR_MIRROR, 0);
    `CHK(rd[0], 1'b1)
    level <= 1'b0;
    xfer(1, ACC_ADDR_CTRL0, 32'h81);
    tick(24);
    `CHK(sync_result_q, 1'b0)
    presc_en <= 1'b1;
    level <= 1'b1;
    tick(24);
    `CHK(sync_result_q, 1'b0)
    presc_clk <= 1'b0;
    tick(12);
    `CHK(sync_result_q, 1'b1)
    presc_en <= 1'b0;
    xfer(1, ACC_ADDR_CTRL0, 32'h90);
    tick(24);
    `CHK(async_result_q, 1'b0)
    $display("t_result done");
  endtask : t_result
  task automatic t_irq;
    xfer(1, ACC_ADDR_CTRL1, 32'h80);
    xfer(1, ACC_ADDR_IRQ, 32'h0e);
    level <= 1'b0;
    tick(8);
    xfer(0, ACC_ADDR_IRQ, 0);
    `CHK(rd[IRQ_FLAG], 1'b1)
    `CHK(irq_q, 1'b1)
    xfer(1, ACC_ADDR_IRQ, 32'h0e);
    tick(3);
    `CHK(irq_q, 1'b0)
    level <= 1'b1;
    tick(8);
    `CHK(irq_q, 1'b0)
    xfer(1, ACC_ADDR_CTRL0, 32'h10);
    tick(8);
    `CHK(irq_q, 1'b1)
    xfer(1, ACC_ADDR_IRQ, 32'h07);
    tick(3);
    `CHK(irq_q, 1'b0)
    xfer(0, ACC_ADDR_IRQ, 0);
    `CHK(rd[IRQ_FLAG], 1'b1)
    $display("t_irq done");
  endtask : t_irq
  task automatic t_pin;
    pin_in <= 1'b1;
    xfer(1, ACC_ADDR_PORT, 32'h02);
    xfer(1, ACC_ADDR_CTRL0, 32'ha4);
    tick(3);
    `CHK({pin_oe_q, pin_out_q}, 2'b11)
    xfer(0, ACC_ADDR_PORT, 0);
    `CHK(rd[PORT_PIN], 1'b1)
    xfer(1, ACC_ADDR_CTRL0, 32'h24);
    tick(3);
    `CHK({pin_oe_q, pin_out_q}, 2'b10)
    xfer(1, ACC_ADDR_CTRL0, 32'h04);
    tick(3);
    `CHK({pin_oe_q, pin_out_q}, 2'b11)
    xfer(1, ACC_ADDR_PORT, 32'h04);
    xfer(0, ACC_ADDR_PORT, 0);
    `CHK(rd[PORT_PIN], 1'b0)
    $display("t_pin done");
  endtask : t_pin
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Whole run needs about 220 cycles; generous margin
  initial begin
    tick(5000);
    errors++;
    end_of_test();
  end
  initial begin
    {hresetn, hwrite, level, pin_in, presc_en, haddr, hwdata, htrans} = '0;
    presc_clk = 1'b1;
    hsel = 1'b1;
    hsize = 3'b010;
    tick(12);
    hresetn <= 1'b1;
    tick(1);
    t_mux();
    t_result();
    t_irq();
    t_pin();
    end_of_test();
  end
endmodule : analog_comparator_control_tb_top
bind acc_top acc_top_asserts chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .comp_raw, .analog_ctrl_q, .async_result_q, .pin_out_q, .pin_oe_q);
`default_nettype wire
